// [rtl/lid_pkg.sv]
// constants, types and defaults for the lcd instruction decoder
// assumes a 100 MHz bus clock and a single AHB-Lite master
package lid_pkg;

    localparam int CLK_NS     = 10;
    localparam int SW_RST_NS  = 1000;
    localparam int SW_RST_CYC = (SW_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CMD  = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_CFG  = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0c;
    localparam logic [7:0] OFF_PWR  = 8'h10;

    // display ram geometry
    localparam int NUM_PAGES = 9;
    localparam int NUM_COLS  = 132;
    localparam int RAM_DEPTH = NUM_PAGES * NUM_COLS;
    localparam int IDX_W     = 11;

    // command codes, matched on their fixed upper bits
    localparam logic [6:0] C_DISP    = 7'h57;
    localparam logic [6:0] C_ADC     = 7'h50;
    localparam logic [6:0] C_BIAS    = 7'h51;
    localparam logic [6:0] C_EON     = 7'h52;
    localparam logic [6:0] C_REV     = 7'h53;
    localparam logic [6:0] C_SM      = 7'h56;
    localparam logic [3:0] C_PAGE    = 4'hb;
    localparam logic [3:0] C_COLH    = 4'h1;
    localparam logic [3:0] C_COLL    = 4'h0;
    localparam logic [3:0] C_SHL     = 4'hc;
    localparam logic [3:0] C_TST1    = 4'hf;
    localparam logic [3:0] C_TST2    = 4'h9;
    localparam logic [4:0] C_PWR     = 5'h05;
    localparam logic [4:0] C_RATIO   = 5'h04;
    localparam logic [1:0] C_START   = 2'h1;
    localparam logic [7:0] C_RMW_ON  = 8'he0;
    localparam logic [7:0] C_RMW_OFF = 8'hee;
    localparam logic [7:0] C_RESET   = 8'he2;
    localparam logic [7:0] C_REF     = 8'h81;

    localparam logic [2:0] RATIO_DEF    = 3'h4;
    localparam logic [5:0] CONTRAST_DEF = 6'h20;

    typedef struct packed {
        logic test_mode;
        logic osc_on;
        logic power_save;
        logic static_mode_bit;
        logic rmw;
        logic common_scan_dir;
        logic bias;
        logic all_pixels_on;
        logic invert_display;
        logic seg_reverse;
        logic display_off_flag;
    } lid_mode_t;

    typedef struct packed {
        logic [5:0] start_line_bits;
        logic [3:0] page_bits;
        logic [7:0] column;
    } lid_addr_t;

    typedef struct packed {
        logic       converter_enable;
        logic       regulator_enable;
        logic       follower_enable;
        logic [2:0] ratio_code;
        logic [5:0] contrast_bits;
        logic       indicator_reg_hi;
        logic       indicator_reg_lo;
    } lid_pwr_t;

    typedef struct packed {
        lid_mode_t mode;
        lid_addr_t addr;
        lid_pwr_t  pwr;
    } lid_cfg_t;

    localparam lid_cfg_t CFG_HW_DEF = '{
        mode: '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        addr: '{6'h00, 4'h0, 8'h00},
        pwr:  '{1'b0, 1'b0, 1'b0, RATIO_DEF, CONTRAST_DEF,
                1'b0, 1'b0}
    };

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } lid_st_t;

endpackage

// [rtl/lid_top.sv]
// lcd instruction decoder: command interpreter, status and display ram
// assumes one AHB-Lite master and an async hardware reset pin
// What this block does
// [R1] display on/off command sets the display-off flag from inverted bit 0
// [R2] command 01xxxxxx loads the start line from its low six bits
// [R3] page command loads page; column high command loads column bits 7:4
// [R4] column low command loads column bits 3:0, keeping the upper nibble
// [R5] status read gives busy, segment direction, off flag, reset, zeros
// [R6] data access writes or reads display ram at page and column
// [R7] segment order command stores the direction from bit 0
// [R8] inversion command stores pixel polarity from bit 0
// [R9] all-on command forces every pixel on from bit 0
// [R10] bias command stores the bias select bit, cleared at hardware reset
// [R11] modify-read entered by e0, left by ee, cleared by both resets
// [R12] command e2 runs a software reset of internal functions
// [R13] common scan command takes direction from bit 3, low bits ignored
// [R14] power command stores converter, regulator and follower enables
// [R15] ratio command stores the three bit regulator ratio code
// [R16] byte 81 arms contrast; next byte's low six bits become contrast
// [R17] static indicator command sets mode; next byte gives two bits
// [R18] display off together with all-on means power save
// [R19] hardware reset loads display off and all mode, power enable and indicator bits clear
// [R20] both resets clear addresses and load ratio and contrast defaults
// [R21] during either reset command writes and data accesses are dropped; status and register readbacks are served
// [R22] the system applies the hardware reset before first use
// [R23] each display data write, and each data read outside modify-read, steps the column by one
// [R24] host discards one read after setting the column
// [R25] busy follows the reset-in-progress flag for either reset
`timescale 1ns/1ps
module lid_top (
    // bus clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    // hardware reset pin, asynchronous to hclk
    input  wire logic              hw_reset_n,
    // panel configuration towards the drivers
    output lid_pkg::lid_cfg_t      panel_cfg
);

    lid_pkg::lid_st_t    st_q;
    lid_pkg::lid_cfg_t   cfg_q;
    lid_pkg::lid_cfg_t   cfg_d;
    logic                hw_s1_q;
    logic                hw_s2_q;
    logic                hreadyout_q;
    logic [31:0]         hrdata_q;
    logic [7:0]          addr_q;
    logic                wr_q;
    logic                ref_pend_q;
    logic                ref_pend_d;
    logic                ind_pend_q;
    logic                ind_pend_d;
    logic [lid_pkg::CNT_W-1:0] cnt_q;
    logic [lid_pkg::CNT_W-1:0] cnt_d;
    logic [7:0]          rd_buf_q;
    logic [31:0]         rd_val;
    logic [7:0]          ram_q [lid_pkg::RAM_DEPTH];

    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
        end else begin
            hw_s1_q <= hw_reset_n;
            hw_s2_q <= hw_s1_q;
        end
    end

    wire hw_rst = !hw_s2_q;
    wire sw_rst = (cnt_q != '0);
    wire busy   = hw_rst || sw_rst; // [R25]

    // bus decode
    wire acc     = hsel && htrans[1] && hready;
    wire exec    = (st_q == lid_pkg::ST_EXEC);
    wire sel_cmd = (addr_q == lid_pkg::OFF_CMD);
    wire sel_dat = (addr_q == lid_pkg::OFF_DATA);
    wire sel_cfg = (addr_q == lid_pkg::OFF_CFG);
    wire sel_adr = (addr_q == lid_pkg::OFF_ADDR);
    wire sel_pwr = (addr_q == lid_pkg::OFF_PWR);
    // command writes and data accesses are dropped while resetting
    wire wr_cmd  = exec && wr_q && sel_cmd && !busy; // [R21]
    wire wr_dat  = exec && wr_q && sel_dat && !busy; // [R21]
    wire rd_dat  = exec && !wr_q && sel_dat && !busy; // [R21]
    wire [7:0] cb = hwdata[7:0];
    wire plain_cmd = wr_cmd && !ref_pend_q && !ind_pend_q;

    // one wait state per transfer keeps ram reads after writes coherent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q        <= lid_pkg::ST_IDLE;
            hreadyout_q <= 1'b1;
            addr_q      <= 8'h00;
            wr_q        <= 1'b0;
            hrdata_q    <= 32'h0000_0000;
        end else begin
            case (st_q)
                lid_pkg::ST_IDLE: begin
                    if (acc) begin
                        st_q        <= lid_pkg::ST_EXEC;
                        hreadyout_q <= 1'b0;
                        addr_q      <= haddr[7:0];
                        wr_q        <= hwrite;
                    end
                end
                lid_pkg::ST_EXEC: begin
                    st_q        <= lid_pkg::ST_IDLE;
                    hreadyout_q <= 1'b1;
                    if (!wr_q) begin
                        hrdata_q <= rd_val;
                    end
                end
                default: begin
                    st_q <= lid_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign hresp     = 1'b0;

    // display ram addressing
    wire in_range = (cfg_q.addr.page_bits < 4'(lid_pkg::NUM_PAGES))
                 && (cfg_q.addr.column < 8'(lid_pkg::NUM_COLS));
    wire [lid_pkg::IDX_W-1:0] ram_idx =
        lid_pkg::IDX_W'(cfg_q.addr.page_bits * lid_pkg::NUM_COLS)
        + lid_pkg::IDX_W'(cfg_q.addr.column);
    wire [7:0] rd_byte = in_range ? ram_q[ram_idx] : 8'h00;
    // modify-read keeps the column on reads so the write lands there
    wire col_step = wr_dat || (rd_dat && !cfg_q.mode.rmw); // [R23] [R11]

    // ram has no reset: contents survive both resets
    always_ff @(posedge hclk) begin
        if (wr_dat && in_range) begin
            ram_q[ram_idx] <= cb; // [R6]
        end
    end

    wire [7:0] status = {busy, cfg_q.mode.seg_reverse,
                         cfg_q.mode.display_off_flag, busy,
                         4'h0}; // [R5]
    // data reads return the previous fetch, hence the dummy read
    assign rd_val =
        sel_cmd ? 32'(status) :
        sel_dat ? (busy ? 32'h0 : 32'(rd_buf_q)) : // [R6] [R24]
        sel_cfg ? 32'(cfg_q.mode) :
        sel_adr ? 32'(cfg_q.addr) :
        sel_pwr ? 32'(cfg_q.pwr) : 32'h0;

    always_comb begin
        cfg_d      = cfg_q;
        ref_pend_d = ref_pend_q;
        ind_pend_d = ind_pend_q;
        cnt_d      = sw_rst ? cnt_q - lid_pkg::CNT_W'(1) : cnt_q;
        if (wr_cmd) begin
            if (ref_pend_q) begin
                cfg_d.pwr.contrast_bits = cb[5:0]; // [R16]
                ref_pend_d = 1'b0;
            end else if (ind_pend_q) begin
                cfg_d.pwr.indicator_reg_hi = cb[1]; // [R17]
                cfg_d.pwr.indicator_reg_lo = cb[0];
                ind_pend_d = 1'b0;
            end else if (cb == lid_pkg::C_RESET) begin
                cfg_d.mode.rmw             = 1'b0; // [R11]
                cfg_d.mode.static_mode_bit = 1'b0; // [R20]
                cfg_d.mode.common_scan_dir = 1'b0;
                cfg_d.mode.test_mode       = 1'b0;
                cfg_d.addr                 = '0;
                cfg_d.pwr.ratio_code       = lid_pkg::RATIO_DEF;
                cfg_d.pwr.contrast_bits    = lid_pkg::CONTRAST_DEF;
                cfg_d.pwr.indicator_reg_hi = 1'b0;
                cfg_d.pwr.indicator_reg_lo = 1'b0;
                cnt_d = lid_pkg::CNT_W'(lid_pkg::SW_RST_CYC); // [R12]
            end else if (cb == lid_pkg::C_REF) begin
                ref_pend_d = 1'b1; // [R16]
            end else if (cb == lid_pkg::C_RMW_ON) begin
                cfg_d.mode.rmw = 1'b1; // [R11]
            end else if (cb == lid_pkg::C_RMW_OFF) begin
                cfg_d.mode.rmw = 1'b0; // [R11]
            end else if (cb[7:1] == lid_pkg::C_DISP) begin
                cfg_d.mode.display_off_flag = !cb[0]; // [R1]
                cfg_d.mode.osc_on = cfg_q.mode.osc_on | cb[0];
            end else if (cb[7:1] == lid_pkg::C_ADC) begin
                cfg_d.mode.seg_reverse = cb[0]; // [R7]
            end else if (cb[7:1] == lid_pkg::C_REV) begin
                cfg_d.mode.invert_display = cb[0]; // [R8]
            end else if (cb[7:1] == lid_pkg::C_EON) begin
                cfg_d.mode.all_pixels_on = cb[0]; // [R9]
            end else if (cb[7:1] == lid_pkg::C_BIAS) begin
                cfg_d.mode.bias = cb[0]; // [R10]
            end else if (cb[7:1] == lid_pkg::C_SM) begin
                cfg_d.mode.static_mode_bit = cb[0]; // [R17]
                ind_pend_d = 1'b1;
            end else if (cb[7:6] == lid_pkg::C_START) begin
                cfg_d.addr.start_line_bits = cb[5:0]; // [R2]
            end else if (cb[7:4] == lid_pkg::C_PAGE) begin
                cfg_d.addr.page_bits = cb[3:0]; // [R3]
            end else if (cb[7:4] == lid_pkg::C_COLH) begin
                cfg_d.addr.column[7:4] = cb[3:0]; // [R3]
            end else if (cb[7:4] == lid_pkg::C_COLL) begin
                cfg_d.addr.column[3:0] = cb[3:0]; // [R4]
            end else if (cb[7:4] == lid_pkg::C_SHL) begin
                cfg_d.mode.common_scan_dir = cb[3]; // [R13]
            end else if (cb[7:3] == lid_pkg::C_PWR) begin
                cfg_d.pwr.converter_enable = cb[2]; // [R14]
                cfg_d.pwr.regulator_enable = cb[1];
                cfg_d.pwr.follower_enable  = cb[0];
            end else if (cb[7:3] == lid_pkg::C_RATIO) begin
                cfg_d.pwr.ratio_code = cb[2:0]; // [R15]
            end else if (cb[7:4] == lid_pkg::C_TST1
                      || cb[7:4] == lid_pkg::C_TST2) begin
                cfg_d.mode.test_mode = 1'b1;
            end
        end
        if (col_step) begin
            cfg_d.addr.column = cfg_q.addr.column + 8'h01; // [R23]
        end
        cfg_d.mode.power_save = cfg_d.mode.display_off_flag
                              & cfg_d.mode.all_pixels_on; // [R18]
    end

    // the pin reset overrides every pending command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q      <= lid_pkg::CFG_HW_DEF;
            ref_pend_q <= 1'b0;
            ind_pend_q <= 1'b0;
            cnt_q      <= '0;
            rd_buf_q   <= 8'h00;
        end else if (hw_rst) begin
            cfg_q      <= lid_pkg::CFG_HW_DEF; // [R19] [R20]
            ref_pend_q <= 1'b0;
            ind_pend_q <= 1'b0;
            cnt_q      <= '0;
            rd_buf_q   <= 8'h00;
        end else begin
            cfg_q      <= cfg_d;
            ref_pend_q <= ref_pend_d;
            ind_pend_q <= ind_pend_d;
            cnt_q      <= cnt_d;
            if (rd_dat) begin
                rd_buf_q <= rd_byte; // [R24]
            end
        end
    end

    assign panel_cfg = cfg_q;

    localparam int RST_LAST = lid_pkg::SW_RST_CYC;

    chk_disp_display_off_flag: assert property ( // [R1]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:1] == lid_pkg::C_DISP
        |=> cfg_q.mode.display_off_flag == !$past(cb[0]))
        else $error("display on/off not applied");

    chk_start_line: assert property ( // [R2]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:6] == lid_pkg::C_START
        |=> cfg_q.addr.start_line_bits == $past(cb[5:0]))
        else $error("start line not loaded");

    chk_page_load: assert property ( // [R3]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:4] == lid_pkg::C_PAGE
        |=> cfg_q.addr.page_bits == $past(cb[3:0]))
        else $error("page not loaded");

    chk_col_low: assert property ( // [R4]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:4] == lid_pkg::C_COLL
        |=> cfg_q.addr.column == {$past(cfg_q.addr.column[7:4]),
                                  $past(cb[3:0])})
        else $error("column low nibble wrong");

    chk_status_byte: assert property ( // [R5]
        @(posedge hclk) disable iff (!hresetn)
        exec && !wr_q && sel_cmd
        |=> hrdata[3:0] == 4'h0 && hrdata[4] == $past(busy)
            && hrdata[7] == hrdata[4])
        else $error("status byte wrong");

    chk_col_step: assert property ( // [R23]
        @(posedge hclk) disable iff (!hresetn)
        wr_dat |=> cfg_q.addr.column
                   == 8'($past(cfg_q.addr.column) + 8'h01))
        else $error("column did not advance");

    chk_rmw_hold: assert property ( // [R11]
        @(posedge hclk) disable iff (!hresetn)
        rd_dat && cfg_q.mode.rmw |=> $stable(cfg_q.addr.column))
        else $error("column moved in modify-read");

    chk_busy_block: assert property ( // [R21]
        @(posedge hclk) disable iff (!hresetn)
        exec && wr_q && sw_rst && !hw_rst |=> $stable(cfg_q))
        else $error("write accepted during reset");

    chk_contrast_load: assert property ( // [R16]
        @(posedge hclk) disable iff (!hresetn)
        wr_cmd && ref_pend_q
        |=> cfg_q.pwr.contrast_bits == $past(cb[5:0]) && !ref_pend_q)
        else $error("contrast byte not stored");

    chk_swrst_busy: assert property ( // [R20] [R25]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb == lid_pkg::C_RESET
        |=> (busy && cfg_q.pwr.ratio_code == lid_pkg::RATIO_DEF
             && cfg_q.addr == '0) ##RST_LAST !busy)
        else $error("software reset wrong");

    chk_hw_defaults: assert property ( // [R19]
        @(posedge hclk) disable iff (!hresetn)
        hw_rst |=> cfg_q == lid_pkg::CFG_HW_DEF)
        else $error("hardware reset defaults wrong");

    chk_col_high: assert property ( // [R3]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:4] == lid_pkg::C_COLH
        |=> cfg_q.addr.column[7:4] == $past(cb[3:0]))
        else $error("column high nibble wrong");

    chk_seg_order: assert property ( // [R7]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:1] == lid_pkg::C_ADC
        |=> cfg_q.mode.seg_reverse == $past(cb[0]))
        else $error("segment order not applied");

    chk_invert_load: assert property ( // [R8]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:1] == lid_pkg::C_REV
        |=> cfg_q.mode.invert_display == $past(cb[0]))
        else $error("inversion not applied");

    chk_all_on: assert property ( // [R9]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:1] == lid_pkg::C_EON
        |=> cfg_q.mode.all_pixels_on == $past(cb[0]))
        else $error("all-on not applied");

    chk_bias_load: assert property ( // [R10]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:1] == lid_pkg::C_BIAS
        |=> cfg_q.mode.bias == $past(cb[0]))
        else $error("bias select not applied");

    chk_scan_dir: assert property ( // [R13]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:4] == lid_pkg::C_SHL
        |=> cfg_q.mode.common_scan_dir == $past(cb[3]))
        else $error("common scan order not applied");

    chk_power_bits: assert property ( // [R14]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:3] == lid_pkg::C_PWR
        |=> {cfg_q.pwr.converter_enable, cfg_q.pwr.regulator_enable,
             cfg_q.pwr.follower_enable} == $past(cb[2:0]))
        else $error("power enables not stored");

    chk_ratio_load: assert property ( // [R15]
        @(posedge hclk) disable iff (!hresetn)
        plain_cmd && cb[7:3] == lid_pkg::C_RATIO
        |=> cfg_q.pwr.ratio_code == $past(cb[2:0]))
        else $error("ratio code not stored");

    chk_indicator_load: assert property ( // [R17]
        @(posedge hclk) disable iff (!hresetn)
        wr_cmd && ind_pend_q
        |=> {cfg_q.pwr.indicator_reg_hi, cfg_q.pwr.indicator_reg_lo}
            == $past(cb[1:0]) && !ind_pend_q)
        else $error("indicator byte not stored");

endmodule

// [verification/lid_host_model.sv]
// host processor model: single-word AHB-Lite master
// assumes one slave whose hreadyout is fed back as the bus hready
`timescale 1ns/1ps
module lid_host_model (
    // bus clock
    input  wire logic        hclk,
    // slave answer
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // master request
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [31:0] hwdata
);
    initial begin
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end

    // entered just after a rising edge; waits as long as the slave asks
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] rd);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        // released data lines must not keep looking valid
        hwdata <= ~{24'h0, d};
    endtask
endmodule

// [verification/lid_instruction_decoder_tb.sv]
// self-checking bench for the lcd instruction decoder
// assumes lid_top and the host model; hsel and hsize are tied
`timescale 1ns/1ps
module lid_instruction_decoder_tb;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  off;
        logic [31:0] mask;
        logic [31:0] exp;
    } lid_row_t;

    localparam lid_row_t ROWS [23] = '{
        '{8'haf, 8'h08, 32'h201, 32'h200},
        '{8'hae, 8'h08, 32'h001, 32'h001},
        '{8'ha1, 8'h08, 32'h002, 32'h002},
        '{8'ha7, 8'h08, 32'h004, 32'h004},
        '{8'ha5, 8'h08, 32'h108, 32'h108},
        '{8'ha3, 8'h08, 32'h010, 32'h010},
        '{8'hf0, 8'h08, 32'h400, 32'h400},
        '{8'hc8, 8'h08, 32'h020, 32'h020},
        '{8'hc7, 8'h08, 32'h020, 32'h000},
        '{8'hc8, 8'h08, 32'h020, 32'h020},
        '{8'he0, 8'h08, 32'h040, 32'h040},
        '{8'hee, 8'h08, 32'h040, 32'h000},
        '{8'he0, 8'h08, 32'h040, 32'h040},
        '{8'had, 8'h08, 32'h080, 32'h080},
        '{8'h03, 8'h10, 32'h003, 32'h003},
        '{8'h7f, 8'h0c, 32'h3f000, 32'h3f000},
        '{8'hb8, 8'h0c, 32'h00f00, 32'h00800},
        '{8'h1a, 8'h0c, 32'h000f0, 32'h000a0},
        '{8'h05, 8'h0c, 32'h000ff, 32'h000a5},
        '{8'h2f, 8'h10, 32'h3800, 32'h3800},
        '{8'h23, 8'h10, 32'h0700, 32'h0300},
        '{8'h81, 8'h10, 32'h00fc, 32'h0080},
        '{8'hff, 8'h10, 32'h00fc, 32'h00fc}
    };

    logic               hclk;
    logic               hresetn;
    logic               hw_reset_n;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [31:0]        hwdata;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    lid_pkg::lid_cfg_t  panel_cfg;
    logic [31:0]        rd;
    int                 fails;
    int                 cmp_count;
    int                 cyc;
    int                 n;

    lid_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .hw_reset_n(hw_reset_n), .panel_cfg(panel_cfg)
    );

    lid_host_model host_u (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata)
    );

    always #5 hclk = ~hclk;

    // the whole run needs well under a few thousand cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] exp,
                         input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        host_u.xfer(1'b0, a, 8'h00, rd);
        check(what, {16'h0, exp}, {16'h0, rd});
    endtask

    // polls status until the reset-in-progress bit drops
    task automatic wait_idle();
        n = 0;
        rd = 32'h10;
        while (rd[4] !== 1'b0 && n < 200) begin
            host_u.xfer(1'b0, lid_pkg::OFF_CMD, 8'h00, rd);
            n++;
        end
        // a device stuck in reset must not slip through as a pass
        if (rd[4] !== 1'b0) begin
            fails++;
            $display("wrong value reset flag expected 0 seen %b", rd[4]);
        end
    endtask

    task automatic check_defaults();
        rd_chk("mode", lid_pkg::OFF_CFG, 32'h001);
        rd_chk("addr", lid_pkg::OFF_ADDR, 32'h0);
        rd_chk("pwr", lid_pkg::OFF_PWR, 32'h480);
        check("panel_cfg", {5'h0, 11'h001, 18'h0, 14'h480},
              {5'h0, panel_cfg});
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hw_reset_n = 1'b0;
        fails = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        hw_reset_n <= 1'b1;
        @(posedge hclk);
        wait_idle();
        check_defaults();
        foreach (ROWS[i]) begin
            wr(lid_pkg::OFF_CMD, ROWS[i].cmd);
            host_u.xfer(1'b0, ROWS[i].off, 8'h00, rd);
            check($sformatf("cmd %h", ROWS[i].cmd), {16'h0, ROWS[i].exp},
                  {16'h0, rd & ROWS[i].mask});
        end
        rd_chk("status", lid_pkg::OFF_CMD, 32'h60);
        // software reset, with a command that must be dropped while busy
        wr(lid_pkg::OFF_CMD, 8'he2);
        rd_chk("status busy", lid_pkg::OFF_CMD, 32'hf0);
        wr(lid_pkg::OFF_CMD, 8'hb3);
        wait_idle();
        check("busy polls", 48'h1, {47'h0, n > 20 && n < 45});
        rd_chk("mode sw", lid_pkg::OFF_CFG, 32'h31f);
        rd_chk("addr sw", lid_pkg::OFF_ADDR, 32'h0);
        rd_chk("pwr sw", lid_pkg::OFF_PWR, 32'h3c80);
        // display data walk along page 2 from column 10
        wr(lid_pkg::OFF_CMD, 8'hb2);
        wr(lid_pkg::OFF_CMD, 8'h10);
        wr(lid_pkg::OFF_CMD, 8'h0a);
        wr(lid_pkg::OFF_DATA, 8'h11);
        wr(lid_pkg::OFF_DATA, 8'h22);
        wr(lid_pkg::OFF_DATA, 8'h33);
        rd_chk("addr walk", lid_pkg::OFF_ADDR, 32'h20d);
        wr(lid_pkg::OFF_CMD, 8'h10);
        wr(lid_pkg::OFF_CMD, 8'h0a);
        host_u.xfer(1'b0, lid_pkg::OFF_DATA, 8'h00, rd);
        rd_chk("data 0", lid_pkg::OFF_DATA, 32'h11);
        rd_chk("data 1", lid_pkg::OFF_DATA, 32'h22);
        rd_chk("data 2", lid_pkg::OFF_DATA, 32'h33);
        // modify-read: reads leave the column where it is
        wr(lid_pkg::OFF_CMD, 8'he0);
        host_u.xfer(1'b0, lid_pkg::OFF_DATA, 8'h00, rd);
        rd_chk("addr rmw", lid_pkg::OFF_ADDR, 32'h20e);
        wr(lid_pkg::OFF_CMD, 8'hee);
        // unmapped place and a read-only readback
        rd_chk("unmapped", 8'h20, 32'h0);
        wr(8'h20, 8'hff);
        wr(lid_pkg::OFF_CFG, 8'h00);
        rd_chk("mode ro", lid_pkg::OFF_CFG, 32'h31f);
        // hardware reset pin in mid-run
        hw_reset_n <= 1'b0;
        repeat (5) @(posedge hclk);
        rd_chk("status hw", lid_pkg::OFF_CMD, 32'hb0);
        wr(lid_pkg::OFF_CMD, 8'ha1);
        hw_reset_n <= 1'b1;
        wait_idle();
        check("hw polls", 48'h1, {47'h0, n > 1 && n < 4});
        check_defaults();
        check("hresp", 48'h0, {47'h0, hresp});
        report_and_stop();
    end
endmodule
